// *** rtl/cam_top.sv ***
// capture/compare counter array: shared counter, four modules, wishbone registers
//
// How it works
// (RULE1) rising pin edge captures sixteen-bit counter
// (RULE2) falling pin edge captures sixteen-bit counter
// (RULE3) both enables capture on either edge
// (RULE4) capture copies counter bytes into compare registers
// (RULE5) interrupt when flag and its enable set
// (RULE6) compare plus match: software timer sets flag
// (RULE7) toggle, match, compare bits select fast output
// (RULE8) fast output inverts pin on each match
// (RULE9) all mode bits clear means no operation
// (RULE10) pwm needs pwm and compare bits only
// (RULE11) all pwm outputs share one counter frequency
// (RULE12) pin low while low byte below compare
// (RULE13) reload active value when low byte wraps
// (RULE14) buffered ninth bit is aux bit one
// (RULE15) duty equals one minus buffered over 256
// (RULE16) flag set by hardware, cleared by software
// (RULE17) active ninth bit is aux bit zero
// (RULE18) software starts and stops counter with run
// (RULE19) matches evaluated once per counter increment
// (RULE20) pins synchronised before edge detection
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module cam_top #(
	parameter int unsigned NUM_MOD = cam_pkg::NUM_MOD
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// wishbone slave
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [7:0]         adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	// module pins
	input  wire logic [NUM_MOD-1:0] module_external_pin_i,
	output logic      [NUM_MOD-1:0] module_external_pin_o,
	output logic      [NUM_MOD-1:0] module_external_pin_oe_o,
	// interrupt request
	output logic                    module_irq_o
);
	if (NUM_MOD < 1 || NUM_MOD > 4) begin : g_bad_num
		$error("NUM_MOD must be 1 to 4");
	end

	////////////////////////////////////////////////////////////////////////
	// state
	logic               ack_q;
	logic [31:0]        dat_q;
	logic               run_q;
	logic [7:0]         prescale_q;
	logic [7:0]         div_q;
	logic [15:0]        counter_q;
	logic               tick_q;
	logic               adv_q;
	logic [NUM_MOD-1:0] flag_q;
	logic [NUM_MOD-1:0] flag_d;
	logic               irq_q;

	cam_ch_if chs [NUM_MOD] ();

	////////////////////////////////////////////////////////////////////////
	// bus decode
	wire       req      = cyc_i & stb_i & ~ack_q;
	wire       wr       = req & we_i;
	wire       lane0    = sel_i[0];
	wire       lane1    = sel_i[1];
	wire       hit_ctrl = adr_i == cam_pkg::OFS_CTRL;
	wire       hit_pre  = adr_i == cam_pkg::OFS_PRESCALE;
	wire       hit_cnt  = adr_i == cam_pkg::OFS_COUNTER;
	wire       hit_flg  = adr_i == cam_pkg::OFS_FLAGS;
	wire [3:0] blk      = adr_i[7:4];
	wire [3:0] sub      = adr_i[3:0];
	wire [3:0] blk_idx  = blk - cam_pkg::MOD_BLK_FIRST;
	wire       hit_blk  = (blk >= cam_pkg::MOD_BLK_FIRST)
		&& ({28'h0, blk_idx} < NUM_MOD);

	// per-module readback and events gathered for the mux
	logic [6:0]         mode_a [NUM_MOD];
	logic [7:0]         low_a  [NUM_MOD];
	logic [7:0]         high_a [NUM_MOD];
	logic [1:0]         aux_a  [NUM_MOD];
	logic [NUM_MOD-1:0] evt_v;
	logic [NUM_MOD-1:0] irq_en_v;

	////////////////////////////////////////////////////////////////////////
	// modules
	for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
		wire mine = hit_blk && (blk_idx == 4'(g)) && wr && lane0;
		assign chs[g].cnt     = counter_q;        // one counter for all [RULE11]
		assign chs[g].tick    = tick_q;
		assign chs[g].adv     = adv_q;
		assign chs[g].wdata   = dat_i[7:0];
		assign chs[g].wr_mode = mine && (sub == cam_pkg::OFS_MODE);
		assign chs[g].wr_low  = mine && (sub == cam_pkg::OFS_CMP_LOW);
		assign chs[g].wr_high = mine && (sub == cam_pkg::OFS_CMP_HIGH);
		assign chs[g].wr_aux  = mine && (sub == cam_pkg::OFS_AUX);
		assign chs[g].pin_raw = module_external_pin_i[g];
		assign mode_a[g]      = chs[g].mode;
		assign low_a[g]       = chs[g].low;
		assign high_a[g]      = chs[g].high;
		assign aux_a[g]       = chs[g].aux;
		assign evt_v[g]       = chs[g].evt;
		assign irq_en_v[g]    = chs[g].mode[cam_pkg::MB_IRQ_EN];
		assign module_external_pin_o[g]    = chs[g].pin_o;
		assign module_external_pin_oe_o[g] = chs[g].pin_oe;
		cam_channel u_chan (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.ch    (chs[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// read mux
	wire [1:0]  ri      = blk_idx[1:0];
	wire [31:0] rd_blk  =
		(sub == cam_pkg::OFS_MODE)     ? {25'h0, mode_a[ri]} :
		(sub == cam_pkg::OFS_CMP_LOW)  ? {24'h0, low_a[ri]} :
		(sub == cam_pkg::OFS_CMP_HIGH) ? {24'h0, high_a[ri]} :
		(sub == cam_pkg::OFS_AUX)      ? {30'h0, aux_a[ri]} : 32'h0;
	wire [31:0] rd_flg  = 32'(flag_q);
	wire [31:0] rd_data =
		hit_ctrl ? {31'h0, run_q} :
		hit_pre  ? {24'h0, prescale_q} :
		hit_cnt  ? {16'h0, counter_q} :
		hit_flg  ? rd_flg :
		hit_blk  ? rd_blk : 32'h0;   // unmapped reads answer zero

	// answer one cycle after the request, then drop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			ack_q <= req;
			if (req && !we_i) dat_q <= rd_data;
		end
	end
	assign ack_o = ack_q;
	assign dat_o = dat_q;

	////////////////////////////////////////////////////////////////////////
	// counter control; software owns the run bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_q      <= 1'b0;
			prescale_q <= cam_pkg::RST_PRESCALE;
		end else begin
			if (wr && lane0 && hit_ctrl) run_q <= dat_i[cam_pkg::CTRL_RUN_BIT];  // [RULE18]
			if (wr && lane0 && hit_pre) prescale_q <= dat_i[7:0];
		end
	end

	// prescaler: an increment every prescale+1 cycles while running
	wire div_end = div_q >= prescale_q;   // a smaller prescale written mid-count cannot stall
	wire inc     = run_q & div_end;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q <= 8'h00;
		end else if (!run_q || div_end) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// shared counter; bus writes per byte lane, increments win only when not written
	wire wr_cnt = wr && hit_cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			counter_q <= cam_pkg::RST_COUNTER;
		end else if (wr_cnt && (lane0 || lane1)) begin
			if (lane0) counter_q[7:0] <= dat_i[7:0];
			if (lane1) counter_q[15:8] <= dat_i[15:8];
		end else if (inc) begin
			counter_q <= counter_q + 16'h0001;
		end
	end

	// tick and adv both mark the cycle after an increment;
	// a stalled counter never re-arms the compare
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_q <= 1'b0;
			adv_q  <= 1'b0;
		end else begin
			tick_q <= inc & ~wr_cnt;
			adv_q  <= inc & ~wr_cnt;                                             // [RULE19]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event flags: written zero clears, hardware set wins the same cycle
	wire clr_flg = wr && lane0 && hit_flg;
	always_comb begin
		flag_d = flag_q;
		if (clr_flg) flag_d = flag_q & dat_i[NUM_MOD-1:0];
		flag_d = flag_d | evt_v;                                               // [RULE16]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= '0;
			irq_q  <= 1'b0;
		end else begin
			flag_q <= flag_d;
			irq_q  <= |(flag_d & irq_en_v);                                        // [RULE5]
		end
	end
	assign module_irq_o = irq_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_ack_one;
		@(posedge clk_i) disable iff (rst_i)
		ack_q |=> !ack_q;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held too long");

	property p_ack_follow;
		@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_q) |=> ack_q;
	endproperty
	a_ack_follow: assert property (p_ack_follow) else $error("request not answered");

	property p_flag_set;
		@(posedge clk_i) disable iff (rst_i)
		evt_v[0] |=> flag_q[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event lost"); // [RULE16]

	property p_flag_hold;
		@(posedge clk_i) disable iff (rst_i)
		(flag_q[0] && !clr_flg) |=> flag_q[0];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by itself"); // [RULE16]

	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
		##1 irq_q == |($past(flag_d) & $past(irq_en_v));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch"); // [RULE5]

	property p_stop;
		@(posedge clk_i) disable iff (rst_i)
		(!run_q && !wr_cnt) |=> counter_q == $past(counter_q);
	endproperty
	a_stop: assert property (p_stop) else $error("counter ran while stopped"); // [RULE18]

	property p_adv_once;
		@(posedge clk_i) disable iff (rst_i)
		(adv_q && prescale_q != 8'h00) |=> !adv_q;
	endproperty
	a_adv_once: assert property (p_adv_once) else $error("compare re-armed"); // [RULE19]

	// every compare window opens right after a real increment
	property p_adv_src;
		@(posedge clk_i) disable iff (rst_i)
		adv_q |-> $past(inc);
	endproperty
	a_adv_src: assert property (p_adv_src) else $error("armed without increment"); // [RULE19]

	// a stopped counter never arms the compare or the reload
	property p_tick_stop;
		@(posedge clk_i) disable iff (rst_i)
		!run_q |=> !tick_q && !adv_q;
	endproperty
	a_tick_stop: assert property (p_tick_stop) else $error("armed while stopped"); // [RULE19]

	// the run bit takes the written value
	property p_run_write;
		@(posedge clk_i) disable iff (rst_i)
		(wr && lane0 && hit_ctrl) |=> run_q == $past(dat_i[cam_pkg::CTRL_RUN_BIT]);
	endproperty
	a_run_write: assert property (p_run_write) else $error("run bit not taken"); // [RULE18]

	// only software moves the run bit; hardware never stops the counter
	property p_run_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(wr && lane0 && hit_ctrl) |=> $stable(run_q);
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("run bit moved alone"); // [RULE18]

	// both byte lanes of a counter write land together, no increment beside them
	property p_cnt_write;
		@(posedge clk_i) disable iff (rst_i)
		(wr_cnt && lane0 && lane1) |=> counter_q == $past(dat_i[15:0]);
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");

	// one step per increment, seen alike by every module
	property p_cnt_step;
		@(posedge clk_i) disable iff (rst_i)
		(inc && !wr_cnt) |=> counter_q == $past(counter_q) + 16'h0001;
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter step wrong"); // [RULE11]

	// a written zero clears a flag when no event meets it
	property p_flag_clear;
		@(posedge clk_i) disable iff (rst_i)
		(clr_flg && !dat_i[0] && !evt_v[0]) |=> !flag_q[0];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // [RULE16]

	// no enabled module, no request
	property p_irq_mask;
		@(posedge clk_i) disable iff (rst_i)
		!(|irq_en_v) |=> !irq_q;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq without enable"); // [RULE5]

	// read data is the addressed register as it stood at the taken edge
	property p_read_data;
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i) |=> dat_q == $past(rd_data);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data wrong");

	// read data holds across writes until the next read
	property p_write_quiet;
		@(posedge clk_i) disable iff (rst_i)
		(req && we_i) |=> $stable(dat_q);
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("read data moved on write");

	// no ack without an open cycle
	property p_ack_idle;
		@(posedge clk_i) disable iff (rst_i)
		!(cyc_i && stb_i) |=> !ack_q;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

	property p_unmapped;
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && !hit_ctrl && !hit_pre && !hit_cnt && !hit_flg && !hit_blk)
			|=> dat_q == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// *** inc/cam_pkg.sv ***
// shared constants for the capture/compare counter array
package cam_pkg;
	localparam int unsigned NUM_MOD        = 4;
	localparam int unsigned ADR_W          = 8;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_PRESCALE   = 8'h04;
	localparam logic [7:0]  OFS_COUNTER    = 8'h08;
	localparam logic [7:0]  OFS_FLAGS      = 8'h0c;
	localparam logic [3:0]  MOD_BLK_FIRST  = 4'h1;
	localparam logic [3:0]  OFS_MODE       = 4'h0;
	localparam logic [3:0]  OFS_CMP_LOW    = 4'h4;
	localparam logic [3:0]  OFS_CMP_HIGH   = 4'h8;
	localparam logic [3:0]  OFS_AUX        = 4'hc;
	// mode, aux and control register field positions
	localparam int unsigned MB_IRQ_EN      = 0;
	localparam int unsigned MB_PWM         = 1;
	localparam int unsigned MB_TOGGLE      = 2;
	localparam int unsigned MB_MATCH       = 3;
	localparam int unsigned MB_FALL        = 4;
	localparam int unsigned MB_RISE        = 5;
	localparam int unsigned MB_CMP         = 6;
	localparam int unsigned AUX_ACTIVE_BIT = 0;
	localparam int unsigned AUX_BUF_BIT    = 1;
	localparam int unsigned CTRL_RUN_BIT   = 0;
	// reset values and the low byte's top value
	localparam logic [6:0]  RST_MODE       = 7'h00;
	localparam logic [7:0]  RST_CMP        = 8'h00;
	localparam logic [1:0]  RST_AUX        = 2'h0;
	localparam logic [15:0] RST_COUNTER    = 16'h0000;
	localparam logic [7:0]  RST_PRESCALE   = 8'h00;
	localparam logic [7:0]  LOW_BYTE_TOP   = 8'hff;
endpackage

// *** inc/cam_ch_if.sv ***
// signals between the register/counter core and one compare/capture module
`timescale 1ns/1ps
interface cam_ch_if;
	logic [15:0] cnt;
	logic        tick;
	logic        adv;
	logic        wr_mode;
	logic        wr_low;
	logic        wr_high;
	logic        wr_aux;
	logic [7:0]  wdata;
	logic [6:0]  mode;
	logic [7:0]  low;
	logic [7:0]  high;
	logic [1:0]  aux;
	logic        evt;
	logic        pin_raw;
	logic        pin_o;
	logic        pin_oe;
	modport core (output cnt, tick, adv, wr_mode, wr_low, wr_high, wr_aux, wdata, pin_raw,
		input mode, low, high, aux, evt, pin_o, pin_oe);
	modport chan (input cnt, tick, adv, wr_mode, wr_low, wr_high, wr_aux, wdata, pin_raw,
		output mode, low, high, aux, evt, pin_o, pin_oe);
endinterface

// *** rtl/cam_channel.sv ***
// one compare/capture module: mode decode, capture, match, toggle and pwm
`timescale 1ns/1ps
module cam_channel (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// link to the core
	cam_ch_if.chan    ch
);
	logic [6:0] mode_q;
	logic [7:0] low_q;
	logic [7:0] high_q;
	logic [1:0] aux_q;
	logic       s1_q, s2_q, s3_q;
	logic       evt_q, pin_q, oe_q;

	// mode decode
	wire cmp_en   = mode_q[cam_pkg::MB_CMP];
	wire rise_en  = mode_q[cam_pkg::MB_RISE];
	wire fall_en  = mode_q[cam_pkg::MB_FALL];
	wire mat_en   = mode_q[cam_pkg::MB_MATCH];
	wire tog_en   = mode_q[cam_pkg::MB_TOGGLE];
	wire pwm_en   = mode_q[cam_pkg::MB_PWM];
	wire cap_mode = (rise_en | fall_en) & ~mat_en & ~tog_en & ~pwm_en;
	wire hso_mode = cmp_en & mat_en & tog_en & ~rise_en & ~fall_en & ~pwm_en;   // [RULE7]
	wire pwm_mode = cmp_en & pwm_en & ~rise_en & ~fall_en & ~mat_en & ~tog_en;  // [RULE10]
	// all-clear mode: none of these terms can fire
	wire idle     = ~|mode_q;                                                   // [RULE9]

	// edges seen only after two sync flops; s2 vs s3 gives one transition
	wire rise     = s2_q & ~s3_q;                                               // [RULE20]
	wire fall     = ~s2_q & s3_q;
	wire cap_hit  = cap_mode & ((rise & rise_en) | (fall & fall_en));          // [RULE1] [RULE2] [RULE3]
	// match tested once, the cycle after each increment
	wire equal    = ch.adv & (ch.cnt == {high_q, low_q});                       // [RULE19]
	wire sw_hit   = cmp_en & mat_en & ~pwm_en & ~cap_mode & equal;              // [RULE6]
	wire roll     = ch.tick & (ch.cnt[7:0] == cam_pkg::LOW_BYTE_TOP);
	wire pwm_hi   = {1'b0, ch.cnt[7:0]} >= {aux_q[cam_pkg::AUX_ACTIVE_BIT], low_q}; // [RULE12]

	assign ch.mode   = mode_q;
	assign ch.low    = low_q;
	assign ch.high   = high_q;
	assign ch.aux    = aux_q;
	assign ch.evt    = evt_q;
	assign ch.pin_o  = pin_q;
	assign ch.pin_oe = oe_q;

	// input synchroniser
	always_ff @(posedge clk_i) begin
		s1_q <= ch.pin_raw;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	// storage; hardware capture and reload beat a bus write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= cam_pkg::RST_MODE;
			low_q  <= cam_pkg::RST_CMP;
			high_q <= cam_pkg::RST_CMP;
			aux_q  <= cam_pkg::RST_AUX;
		end else begin
			if (ch.wr_mode) mode_q <= ch.wdata[6:0];
			if (ch.wr_aux) aux_q <= ch.wdata[1:0];
			if (ch.wr_low) low_q <= ch.wdata;
			if (ch.wr_high) high_q <= ch.wdata;
			if (cap_hit) begin
				low_q  <= ch.cnt[7:0];                                       // [RULE4]
				high_q <= ch.cnt[15:8];
			end else if (pwm_mode && roll) begin
				low_q <= high_q;                                           // [RULE13]
				aux_q[cam_pkg::AUX_ACTIVE_BIT] <= aux_q[cam_pkg::AUX_BUF_BIT];   // [RULE14] [RULE17]
			end
		end
	end

	// events and pin drive
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_q <= 1'b0;
			pin_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			evt_q <= ~idle & (cap_hit | sw_hit);                              // [RULE16]
			oe_q  <= hso_mode | pwm_mode;
			if (pwm_mode) pin_q <= pwm_hi;                                    // [RULE15]
			else if (hso_mode && equal) pin_q <= ~pin_q;                      // [RULE8]
		end
	end

	sequence s_cap_edge;
		cap_hit ##1 1'b1;
	endsequence
	property p_cap_load;
		@(posedge clk_i) disable iff (rst_i)
		cap_hit |=> {high_q, low_q} == $past(ch.cnt);
	endproperty
	a_cap_load: assert property (p_cap_load) else $error("capture value wrong"); // [RULE4]
	property p_cap_flag;
		@(posedge clk_i) disable iff (rst_i)
		s_cap_edge |-> evt_q;
	endproperty
	a_cap_flag: assert property (p_cap_flag) else $error("capture gave no event"); // [RULE1]
	property p_hso_toggle;
		@(posedge clk_i) disable iff (rst_i)
		(hso_mode && equal) |=> pin_q != $past(pin_q);
	endproperty
	a_hso_toggle: assert property (p_hso_toggle) else $error("no toggle on match"); // [RULE8]
	property p_pwm_level;
		@(posedge clk_i) disable iff (rst_i)
		pwm_mode |=> pin_q == $past(pwm_hi) && oe_q;
	endproperty
	a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong"); // [RULE12]
	property p_pwm_reload;
		@(posedge clk_i) disable iff (rst_i)
		(pwm_mode && roll && !cap_hit) |=> low_q == $past(high_q)
			&& aux_q[0] == $past(aux_q[1]);
	endproperty
	a_pwm_reload: assert property (p_pwm_reload) else $error("pwm reload missing"); // [RULE13]
	property p_idle_quiet;
		@(posedge clk_i) disable iff (rst_i)
		idle [*2] |=> !evt_q && !oe_q;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle module active"); // [RULE9]
endmodule

// *** tb/cam_pin_model.sv ***
// far-side driver for the module pins: plain external levels
`timescale 1ns/1ps
module cam_pin_model (
	// clock
	input  wire logic       clk_i,
	// wanted levels and driven pins
	input  wire logic [3:0] want_i,
	output logic      [3:0] pin_o
);
	// levels move on the falling edge, off the design's sampling edge
	initial pin_o = 4'h0;
	always @(negedge clk_i) begin
		pin_o <= want_i;
	end
endmodule

// *** tb/cam_top_tb.sv ***
// self-checking bench for the capture/compare counter array
`timescale 1ns/1ps
module cam_top_tb;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i, want, ext, p_out, p_oe;
	logic [31:0] dat_i, dat_o, rd, seed;
	logic [8:0]  v, cnt;
	logic [8:0]  duty_tab [5];
	logic [6:0]  mode;
	int          errors, n_checks;
	// pin level seen by the design: own drive wins over the far side
	wire  logic [3:0] pin_i = (p_oe & p_out) | (~p_oe & ext);

	cam_top dut_u (
		.clk_i                    (clk_i),
		.rst_i                    (rst_i),
		.cyc_i                    (cyc_i),
		.stb_i                    (stb_i),
		.we_i                     (we_i),
		.adr_i                    (adr_i),
		.sel_i                    (sel_i),
		.dat_i                    (dat_i),
		.dat_o                    (dat_o),
		.ack_o                    (ack_o),
		.module_external_pin_i    (pin_i),
		.module_external_pin_o    (p_out),
		.module_external_pin_oe_o (p_oe),
		.module_irq_o             (irq)
	);
	cam_pin_model pin_u (.clk_i(clk_i), .want_i(want), .pin_o(ext));

	////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// high clocks in one 256-step period for a buffered value
	function automatic logic [8:0] duty_exp(input logic [8:0] b);
		return 9'h100 - b;
	endfunction
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle; holds everything until ack, so no fixed latency assumed
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 64);
		if (n >= 64) errors++;
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	// clock, watchdog
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		repeat (50000) @(posedge clk_i);
		errors++;
		final_report();
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst_i, cyc_i, stb_i, we_i} = 4'h8;
		{adr_i, dat_i, want} = '0;
		sel_i = 4'hf;
		seed = 32'h1;
		errors = 0;
		n_checks = 0;
		duty_tab = '{9'h000, 9'h040, 9'h0c0, 9'h100, 9'h0ff};
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values of all module registers, then an unmapped place
		for (int m = 1; m <= 4; m++) for (int o = 0; o < 16; o += 4) begin
			wb(1'b0, 8'(m * 16 + o), 32'h0);
			chk_reg(rd, 32'h0);
		end
		wb(1'b1, 8'h80, 32'h5a);
		wb(1'b0, 8'h80, 32'h0);
		chk_reg(rd, 32'h0);
		// prescale read back, then back to one increment per clock
		seed = xorshift(seed);
		wb(1'b1, 8'h04, {24'h0, seed[7:0]});
		wb(1'b0, 8'h04, 32'h0);
		chk_reg(rd, {24'h0, seed[7:0]});
		wb(1'b1, 8'h04, 32'h0);
		// capture modes on a stopped counter so the copied value is known
		for (int k = 0; k < 3; k++) begin
			mode = (k == 0) ? 7'h20 : (k == 1) ? 7'h10 : 7'h30;
			wb(1'b1, 8'h10, {25'h0, mode});
			for (int e = 0; e < 2; e++) begin
				seed = xorshift(seed);
				wb(1'b1, 8'h08, {16'h0, seed[15:0]});
				wb(1'b0, 8'h08, 32'h0);
				chk_reg(rd, {16'h0, seed[15:0]});
				wb(1'b1, 8'h0c, 32'he);
				@(posedge clk_i);
				want[0] <= (e == 0);
				repeat (8) @(posedge clk_i);
				wb(1'b0, 8'h0c, 32'h0);
				chk_reg({31'h0, rd[0]}, {31'h0, e == 0 ? mode[5] : mode[4]});
				if ((e == 0 && mode[5]) || (e == 1 && mode[4])) begin
					wb(1'b0, 8'h14, 32'h0);
					chk_reg(rd, {24'h0, seed[7:0]});
					wb(1'b0, 8'h18, 32'h0);
					chk_reg(rd, {24'h0, seed[15:8]});
				end
			end
		end
		// software timer on module 1, interrupt first masked then enabled
		wb(1'b1, 8'h24, 32'h10);
		wb(1'b1, 8'h20, 32'h48);
		wb(1'b1, 8'h08, 32'h0);
		wb(1'b1, 8'h00, 32'h1);
		repeat (40) @(posedge clk_i);
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b0, 8'h0c, 32'h0);
		chk_reg(rd & 32'h2, 32'h2);
		chk_pin({8'h0, irq}, 9'h0);
		wb(1'b1, 8'h20, 32'h49);
		repeat (3) @(posedge clk_i);
		chk_pin({8'h0, irq}, 9'h1);
		wb(1'b1, 8'h0c, 32'hf);
		wb(1'b0, 8'h0c, 32'h0);
		chk_reg(rd & 32'h2, 32'h2);
		wb(1'b1, 8'h0c, 32'hd);
		repeat (3) @(posedge clk_i);
		chk_pin({8'h0, irq}, 9'h0);
		wb(1'b1, 8'h20, 32'h0);
		// fast output on module 2; module 3 stays idle while its pin moves
		wb(1'b1, 8'h34, 32'h8);
		wb(1'b1, 8'h30, 32'h4c);
		wb(1'b1, 8'h08, 32'h0);
		want[3] <= 1'b1;
		wb(1'b1, 8'h00, 32'h1);
		repeat (30) @(posedge clk_i);
		wb(1'b1, 8'h00, 32'h0);
		chk_pin({7'h0, p_oe[2], p_out[2]}, 9'h3);
		chk_pin({8'h0, p_oe[3]}, 9'h0);
		wb(1'b0, 8'h0c, 32'h0);
		chk_reg(rd & 32'hc, 32'h4);
		// pwm on module 0: table corners plus one random duty
		wb(1'b1, 8'h10, 32'h42);
		wb(1'b1, 8'h00, 32'h1);
		wb(1'b0, 8'h00, 32'h0);
		chk_reg(rd, 32'h1);
		for (int i = 0; i < 6; i++) begin
			seed = xorshift(seed);
			v = (i < 5) ? duty_tab[i] : {1'b0, seed[7:0]};
			wb(1'b1, 8'h18, {24'h0, v[7:0]});
			wb(1'b1, 8'h1c, {30'h0, v[8], 1'b0});
			repeat (600) @(posedge clk_i);
			cnt = 9'h0;
			repeat (256) begin
				@(posedge clk_i);
				cnt = cnt + {8'h0, p_out[0]};
			end
			chk_pin(cnt, duty_exp(v));
			chk_pin({8'h0, p_oe[0]}, 9'h1);
			wb(1'b0, 8'h1c, 32'h0);
			chk_reg(rd, {30'h0, v[8], v[8]});
			wb(1'b0, 8'h14, 32'h0);
			chk_reg(rd, {24'h0, v[7:0]});
		end
		final_report();
	end
endmodule
